// [rtl/bsx_cfg.svh]
// bsx_cfg.svh: opcode patterns, field positions and widths for the decoder
// assumes it is included by its bare name from the package and the modules
`ifndef BSX_CFG_SVH
`define BSX_CFG_SVH

// instruction word and field layout
`define BSX_IW_W        14
`define BSX_FADDR_LSB   0
`define BSX_FADDR_W     7
`define BSX_BIDX_LSB    7
`define BSX_BIDX_W      3
`define BSX_DEST_BIT    7
`define BSX_PC_W        13
`define BSX_LIT_W       11
// opcode prefixes
`define BSX_OP_BITCLR   4'h4
`define BSX_OP_BITSET   4'h5
`define BSX_OP_BTSC     4'h6
`define BSX_OP_DECSZ    6'h0B
`define BSX_OP_BRANCH   3'h5
// latch bits that feed the upper counter bits
`define BSX_LATCH_HI    4
`define BSX_LATCH_LO    3
// reset values
`define BSX_RST_PC      13'h0000
`define BSX_RST_BYTE    8'h00

`endif

// [rtl/bsx_pkg.sv]
// bsx_pkg.sv: types shared by the bit/skip/branch execute logic
// assumes bsx_cfg.svh is on the include path
`include "bsx_cfg.svh"

package bsx_pkg;

	typedef enum logic [2:0]
	{
		BSX_NONE,
		BSX_BIT_CLEAR,
		BSX_BIT_SET,
		BSX_BIT_TEST_SKIP,
		BSX_DEC_SKIP,
		BSX_BRANCH
	} bsx_op_type;

	// decoded fields of one instruction word
	typedef struct packed
	{
		bsx_op_type          op;
		logic [6:0]          faddr;
		logic [2:0]          bidx;
		logic                dest_f;
		logic [10:0]         lit;
	} bsx_dec_type;

	// file register access toward the data space
	typedef struct packed
	{
		logic                we;
		logic [6:0]          addr;
		logic [7:0]          wdata;
	} bsx_fwr_type;

endpackage

// [rtl/bsx_decode.sv]
// bsx_decode.sv: combinational split of a 14-bit word into op and fields
// assumes the word comes from the core fetch stage on the same clock
`timescale 1ns/10ps
`include "bsx_cfg.svh"

module bsx_decode
(
	input  wire logic [13:0]         instr,
	output bsx_pkg::bsx_dec_type     dec
);
	import bsx_pkg::*;

	// opcode from top bits, operand fields from the rest
	always_comb
	begin
		dec        = '0;
		dec.faddr  = instr[`BSX_FADDR_LSB +: `BSX_FADDR_W];       // RULE9
		dec.bidx   = instr[`BSX_BIDX_LSB +: `BSX_BIDX_W];         // RULE9
		dec.dest_f = instr[`BSX_DEST_BIT];
		dec.lit    = instr[`BSX_LIT_W-1:0];
		if (instr[13:10] == `BSX_OP_BITCLR)
			dec.op = BSX_BIT_CLEAR;                         // RULE9
		else if (instr[13:10] == `BSX_OP_BITSET)
			dec.op = BSX_BIT_SET;                           // RULE9
		else if (instr[13:10] == `BSX_OP_BTSC)
			dec.op = BSX_BIT_TEST_SKIP;                     // RULE9
		else if (instr[13:8] == `BSX_OP_DECSZ)
			dec.op = BSX_DEC_SKIP;                          // RULE9
		else if (instr[13:11] == `BSX_OP_BRANCH)
			dec.op = BSX_BRANCH;                            // RULE9
		else
			dec.op = BSX_NONE;
	end

endmodule

// [rtl/bsx_exec.sv]
// bsx_exec.sv: execute stage for bit clear/set, bit test skip,
// decrement skip and unconditional branch
// assumes the fetch stage presents a word with instr_valid each cycle,
// a file read port answers in the same cycle (combinational rdata),
// and the core owns the counter unless pc_load is high;
// the fetch stage must drop its prefetched word while flush is high,
// and the core applies f_wr, w_we and pc_load one cycle after the word
`timescale 1ns/10ps
`include "bsx_cfg.svh"

// Contract
// RULE1 - bit clear op forces bit b of register f low, one cycle, no flags
// RULE2 - bit set op forces bit b of register f high, one cycle, no flags
// RULE3 - bit test op skips next instruction when bit b of f is zero
// RULE4 - a taken skip drops the prefetched word, runs a nop, two cycles
// RULE5 - decrement op writes f minus one, skips on zero, no flags
// RULE6 - destination bit zero writes working register, one writes f
// RULE7 - zero decrement result drops next word, nop, two cycles total
// RULE8 - branch loads 11-bit literal low, latch bits 4:3 high, two cycles
// RULE9 - decode from top opcode bits, fields taken directly from the word
module bsx_exec
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	// fetch side
	input  wire logic [13:0]         instr,
	input  wire logic                instr_valid,
	input  wire logic [7:0]          counter_high_latch,
	// file space
	output logic [6:0]               f_raddr,
	input  wire logic [7:0]          f_rdata,
	output bsx_pkg::bsx_fwr_type     f_wr,
	// working register and counter
	output logic                     w_we,
	output logic [7:0]               w_wdata,
	output logic                     pc_load,
	output logic [12:0]              pc_target,
	// fetch control and status
	output logic                     flush,
	output logic                     busy,
	output logic                     flags_we,
	output bsx_pkg::bsx_op_type      op_done
);
	import bsx_pkg::*;

	typedef enum logic [1:0]
	{
		ST_EXEC,
		ST_NOP
	} bsx_state_type;

	bsx_dec_type    dec;
	bsx_state_type  state_q;
	bsx_state_type  state_d;
	logic [7:0]     bit_mask;
	logic [7:0]     dec_res;
	logic           active;
	logic           skip_take;
	logic           br_take;
	bsx_fwr_type    f_wr_d;
	logic           w_we_d;
	logic [12:0]    br_dest;

	// one-hot mask for the selected bit
	function automatic logic [7:0] bit_sel(input logic [2:0] idx);
		bit_sel = 8'h01 << idx;
	endfunction

	bsx_decode u_decode
	(
		.instr (instr),
		.dec   (dec)
	);

	// a word is executed only in the normal state
	assign active   = instr_valid && (state_q == ST_EXEC);

	// operand address and bit select straight from the word
	assign bit_mask = bit_sel(dec.bidx);
	assign f_raddr  = dec.faddr;

	// decrement wraps from zero to all ones
	assign dec_res  = 8'(f_rdata - 8'h01);                  // RULE5

	// decrement routed to the working register when d is zero
	assign w_we_d   = active && dec.op == BSX_DEC_SKIP
		&& !dec.dest_f;                                 // RULE6

	// branch target: latch bits on top of the literal
	assign br_dest  = {counter_high_latch[`BSX_LATCH_HI:`BSX_LATCH_LO],
		dec.lit};                                       // RULE8

	// skip decisions from the operand just read
	always_comb
	begin
		skip_take = 1'b0;
		br_take   = 1'b0;
		if (active)
		begin
			case (dec.op)
				BSX_BIT_TEST_SKIP:
					skip_take = (f_rdata & bit_mask) == 8'h00;  // RULE3
				BSX_DEC_SKIP:
					skip_take = dec_res == 8'h00;           // RULE5 RULE7
				BSX_BRANCH:
					br_take = 1'b1;                         // RULE8
				default:
					skip_take = 1'b0;
			endcase
		end
	end

	// second cycle runs a nop in place of the discarded word
	always_comb
	begin
		case (state_q)
			ST_EXEC:
				state_d = (skip_take || br_take) ? ST_NOP : ST_EXEC;  // RULE4
			ST_NOP:
				state_d = ST_EXEC;                              // RULE4 RULE7
			default:
				state_d = ST_EXEC;
		endcase
	end

	// control state
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= ST_EXEC;
		else
			state_q <= state_d;
	end

	// prefetched word is thrown away while flush is high
	assign flush    = skip_take || br_take;                 // RULE4 RULE7
	assign busy     = state_q == ST_NOP;

	// none of these operations touches the status flags
	assign flags_we = 1'b0;                          // RULE1 RULE2 RULE3 RULE5

	// next file write: clear, set or decrement back into f
	always_comb
	begin
		f_wr_d      = '0;
		f_wr_d.addr = dec.faddr;
		if (active)
		begin
			case (dec.op)
				BSX_BIT_CLEAR:
				begin
					f_wr_d.we    = 1'b1;
					f_wr_d.wdata = f_rdata & ~bit_mask; // RULE1
				end
				BSX_BIT_SET:
				begin
					f_wr_d.we    = 1'b1;
					f_wr_d.wdata = f_rdata | bit_mask;  // RULE2
				end
				BSX_DEC_SKIP:
				begin
					f_wr_d.we    = dec.dest_f;          // RULE6
					f_wr_d.wdata = dec_res;             // RULE5
				end
				default:
					f_wr_d.we    = 1'b0;
			endcase
		end
	end

	// file register write-back, one-cycle write pulse
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			f_wr <= '0;
		else
			f_wr <= f_wr_d;
	end

	// working register write-back
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			w_we    <= 1'b0;
			w_wdata <= `BSX_RST_BYTE;
		end
		else
		begin
			w_we    <= w_we_d;                              // RULE6
			if (w_we_d)
				w_wdata <= dec_res;                         // RULE5
		end
	end

	// branch target toward the program counter
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_load   <= 1'b0;
			pc_target <= `BSX_RST_PC;
		end
		else
		begin
			pc_load <= br_take;                             // RULE8
			if (br_take)
				pc_target <= br_dest;                       // RULE8
		end
	end

	// completed operation report
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			op_done <= BSX_NONE;
		else if (active)
			op_done <= dec.op;
		else
			op_done <= BSX_NONE;                            // RULE4
	end

endmodule

// [tb/bsx_exec_sva.sv]
// bsx_exec_sva.sv: port assertions for the execute block
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
module bsx_chk
(
	input wire logic                sys_clk,
	input wire logic                arst_n,
	input wire logic [13:0]         instr,
	input wire logic                instr_valid,
	input wire logic [7:0]          counter_high_latch,
	input wire logic [7:0]          f_rdata,
	input wire bsx_pkg::bsx_fwr_type f_wr,
	input wire logic                w_we,
	input wire logic [7:0]          w_wdata,
	input wire logic                pc_load,
	input wire logic [12:0]         pc_target,
	input wire logic                flush,
	input wire logic                busy,
	input wire logic                flags_we,
	input wire bsx_pkg::bsx_op_type op_done
);
	import bsx_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// taken word, bit mask, decrement and branch target
	wire        go = instr_valid && !busy;
	wire [7:0]  bm = 8'h01 << instr[9:7];
	wire [7:0]  dv = f_rdata - 8'h01;
	wire [12:0] tg = {counter_high_latch[4:3], instr[10:0]};
	// one nop cycle, then normal flow
	sequence s_nop;
		busy ##1 !busy;
	endsequence
	a_no_flags: assert property (!flags_we)
		else $error("status flag written");
	a_bit_clear: assert property (go && instr[13:10] == 4'h4 |=>
		f_wr.we && f_wr.wdata == ($past(f_rdata) & ~$past(bm)))
		else $error("bit clear wrong");
	a_bit_set: assert property (go && instr[13:10] == 4'h5 |=>
		f_wr.we && f_wr.wdata == ($past(f_rdata) | $past(bm)))
		else $error("bit set wrong");
	a_test_skip: assert property (go && instr[13:10] == 4'h6 |->
		flush == ((f_rdata & bm) == 8'h00))
		else $error("bit test skip wrong");
	a_skip_nop: assert property (flush |=> s_nop)
		else $error("no single nop after skip");
	a_dec_file: assert property (go && instr[13:7] == 7'h17 |=>
		f_wr.we && !w_we && f_wr.wdata == $past(dv))
		else $error("decrement to file wrong");
	a_dec_work: assert property (go && instr[13:7] == 7'h16 |=>
		w_we && !f_wr.we && w_wdata == $past(dv))
		else $error("decrement to work wrong");
	a_dec_skip: assert property (go && instr[13:8] == 6'h0b |->
		flush == (f_rdata == 8'h01))
		else $error("decrement skip wrong");
	a_branch_load: assert property (go && instr[13:11] == 3'h5 |->
		flush ##1 (pc_load && busy && pc_target == $past(tg)))
		else $error("branch load wrong");
	a_done_idle: assert property (!go |=> op_done == BSX_NONE)
		else $error("refused word reported");
	a_done_clear: assert property (go && instr[13:10] == 4'h4 |=>
		op_done == BSX_BIT_CLEAR)
		else $error("bit clear not reported");
endmodule
bind bsx_exec bsx_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.instr(instr), .instr_valid(instr_valid), .f_rdata(f_rdata),
	.counter_high_latch(counter_high_latch), .f_wr(f_wr), .w_we(w_we),
	.w_wdata(w_wdata), .pc_load(pc_load), .pc_target(pc_target),
	.flush(flush), .busy(busy), .flags_we(flags_we),
	.op_done(op_done));

// [tb/bit_ops_skip_branch_exec_bench.sv]
// bit_ops_skip_branch_exec_bench.sv: directed scenarios for bsx_exec
// assumes the file space is modelled here with a combinational read
`timescale 1ns/10ps
module bit_ops_skip_branch_exec_bench;
	import bsx_pkg::*;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic        instr_valid = 1'b0;
	logic [7:0]  counter_high_latch = 8'h00;
	logic [6:0]  f_raddr;
	logic [7:0]  f_rdata;
	bsx_fwr_type f_wr;
	logic [7:0]  w_wdata;
	logic [12:0] pc_target;
	logic [7:0]  mem [128];
	int          n_mismatch = 0;
	int          n_checks = 0;
	// clock and file space
	always #25 sys_clk = ~sys_clk;
	assign f_rdata = mem[f_raddr];
	always @(posedge sys_clk)
		if (f_wr.we)
			mem[f_wr.addr] <= f_wr.wdata;
	bsx_exec u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .instr(instr),
		.instr_valid(instr_valid), .counter_high_latch(counter_high_latch),
		.f_raddr(f_raddr), .f_rdata(f_rdata), .f_wr(f_wr), .w_we(),
		.w_wdata(w_wdata), .pc_load(), .pc_target(pc_target), .flush(),
		.busy(), .flags_we(), .op_done());
	task chk(input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task run(input logic [13:0] w);
		@(negedge sys_clk);
		instr = w;
		instr_valid = 1'b1;
	endtask
	task idle;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask
	// back-to-back clear and set
	task t_bits;
		mem[5] = 8'hc7;
		mem[6] = 8'h0a;
		run({4'h4, 3'h7, 7'h05});
		run({4'h5, 3'h7, 7'h06});
		idle;
		chk(mem[5], 8'h47);
		chk(mem[6], 8'h8a);
	endtask
	// taken skip drops the word behind it, untaken does not
	task t_skip;
		mem[10] = 8'h02;
		run({4'h6, 3'h1, 7'h09});
		run({4'h5, 3'h0, 7'h09});
		run({4'h6, 3'h1, 7'h0a});
		run({4'h5, 3'h0, 7'h0a});
		idle;
		chk(mem[9], 8'h00);
		chk(mem[10], 8'h03);
	endtask
	// decrement to zero skips, then decrement into work
	task t_dec;
		mem[12] = 8'h01;
		mem[13] = 8'h05;
		run({6'h0b, 1'h1, 7'h0c});
		run({4'h5, 3'h7, 7'h0c});
		run({6'h0b, 1'h0, 7'h0d});
		idle;
		chk(mem[12], 8'h00);
		chk(w_wdata, 8'h04);
		chk(mem[13], 8'h05);
	endtask
	// branch target and dropped word after it
	task t_branch;
		counter_high_latch = 8'h18;
		run({3'h5, 11'h5a5});
		run({4'h5, 3'h0, 7'h0e});
		idle;
		chk(pc_target, {2'h3, 11'h5a5});
		chk(mem[14], 8'h00);
	endtask
	task conclude;
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (4) @(negedge sys_clk);
		arst_n = 1'b1;
		t_bits;
		t_skip;
		t_dec;
		t_branch;
		conclude;
	end
	// watchdog: the scenarios need about 31 cycles
	initial
	begin
		#20us;
		n_mismatch++;
		conclude;
	end
endmodule
